// File: verilog/link_ctl_pkg.sv
// Constants and carrier types for the link host control bits block
package link_ctl_pkg;
   // Host access port widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Set and clear offsets of the control register
   localparam logic [ADDR_W-1:0] CTL_SET_OFS = 12'h050;
   localparam logic [ADDR_W-1:0] CTL_CLR_OFS = 12'h054;

   // Register windows that live in the link clock domain
   localparam logic [ADDR_W-1:0] LINKDOM_A_LO = 12'h0dc;
   localparam logic [ADDR_W-1:0] LINKDOM_A_HI = 12'h0f0;
   localparam logic [ADDR_W-1:0] LINKDOM_B_LO = 12'h100;
   localparam logic [ADDR_W-1:0] LINKDOM_B_HI = 12'h11c;

   // Field positions inside the control register
   localparam int OWNER_BIT  = 23;
   localparam int ENH_BIT    = 22;
   localparam int POWER_BIT  = 19;
   localparam int BUFWR_BIT  = 18;
   localparam int ATTACH_BIT = 17;
   localparam int LRST_BIT   = 16;

   // Reset values and fixed read answers
   localparam logic [DATA_W-1:0] CTL_RESET_VAL = 32'h0080_0000;
   localparam logic              OWNER_RESET   = 1'h1;
   localparam logic [DATA_W-1:0] ALL_ONES      = 32'hffff_ffff;
   localparam logic [DATA_W-1:0] READ_ZERO     = 32'h0000_0000;

   // Timing: link clock is seen stopped after two missed periods
   localparam int CLK_PERIOD_NS      = 100;
   localparam int LINK_PERIOD_NS     = 800;
   localparam int LINK_IDLE_NS       = 2 * LINK_PERIOD_NS;
   localparam int LINK_IDLE_CYC      = LINK_IDLE_NS / CLK_PERIOD_NS;
   localparam int LOCAL_RESET_CYC    = 8;

   // Host request and answer carriers
   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } host_req_type;

   typedef struct packed {
      logic              abort;
      logic [DATA_W-1:0] rdata;
   } host_resp_type;
endpackage

// File: verilog/link_host_control_bits.sv
// Lower half of the link host control register with link clock supervision
`timescale 1ns/1ns
`default_nettype none
module link_host_control_bits #(
   parameter int RESET_CYC = link_ctl_pkg::LOCAL_RESET_CYC,
   parameter int IDLE_CYC  = link_ctl_pkg::LINK_IDLE_CYC
) (
   input  wire logic                        clk_sys,
   input  wire logic                        rst_n,
   input  wire logic                        req_valid,
   input  wire link_ctl_pkg::host_req_type  req,
   output var  logic                        resp_valid,
   output var  link_ctl_pkg::host_resp_type resp,
   input  wire logic                        suppress_abort_idle_clock,
   input  wire logic                        eeprom_load_valid,
   input  wire logic                        eeprom_owner_bit,
   input  wire logic                        phy_sclk,
   output var  logic                        link_power_on,
   output var  logic                        phy_enhancements_on,
   output var  logic                        phy_config_owner_flag,
   output var  logic                        buffered_write_on,
   output var  logic                        bus_attach_active,
   output var  logic                        bus_attach_status,
   output var  logic                        link_clock_running,
   output var  logic                        local_reset_active
);

   // Elaboration checks on counts the counters can hold
   initial begin
      if (RESET_CYC < 1 || RESET_CYC > 255) begin
         $error("RESET_CYC out of range");
      end
      if (IDLE_CYC < 2 || IDLE_CYC > 255) begin
         $error("IDLE_CYC out of range");
      end
   end

   localparam logic [7:0] RESET_LAST = 8'(RESET_CYC - 1);
   localparam logic [7:0] IDLE_LAST  = 8'(IDLE_CYC - 1);

   // Control bits on the host clock side
   logic       owner_r;
   logic       owner_nxt;
   logic       enh_r;
   logic       enh_nxt;
   logic       power_r;
   logic       power_nxt;
   logic       bufwr_r;
   logic       bufwr_nxt;
   logic       attach_r;
   logic       attach_nxt;
   logic       lrst_r;
   logic [7:0] lrst_cnt_r;

   // Link clock sampling and supervision
   logic       sclk_s1_r;
   logic       sclk_s2_r;
   logic       sclk_s3_r;
   logic [7:0] idle_cnt_r;
   logic       alive_r;

   // Link side copies and the status path back
   logic       power_lk1_r;
   logic       power_lk2_r;
   logic       attach_lk1_r;
   logic       attach_lk2_r;
   logic       stat_s1_r;
   logic       stat_s2_r;

   // Answer registers
   logic                        resp_valid_r;
   link_ctl_pkg::host_resp_type resp_r;
   link_ctl_pkg::host_resp_type resp_nxt;

   // Request decode
   wire       wr_set    = req_valid & req.write & (req.addr == link_ctl_pkg::CTL_SET_OFS);
   wire       wr_clr    = req_valid & req.write & (req.addr == link_ctl_pkg::CTL_CLR_OFS);
   wire       ctl_hit   = (req.addr == link_ctl_pkg::CTL_SET_OFS) |
                          (req.addr == link_ctl_pkg::CTL_CLR_OFS);
   wire       in_win_a  = (req.addr >= link_ctl_pkg::LINKDOM_A_LO) &
                          (req.addr <= link_ctl_pkg::LINKDOM_A_HI);
   wire       in_win_b  = (req.addr >= link_ctl_pkg::LINKDOM_B_LO) &
                          (req.addr <= link_ctl_pkg::LINKDOM_B_HI);
   wire       link_dom  = in_win_a | in_win_b;
   wire       stalled   = link_dom & ~link_clock_running; // Same view as the status pin
   wire [31:0] wd       = req.wdata;

   // Edge of the sampled link clock acts as the link side enable
   wire       sclk_rise = sclk_s2_r & ~sclk_s3_r;
   wire       lrst_done = lrst_r & (lrst_cnt_r == RESET_LAST);
   wire       lrst_go   = wr_set & wd[link_ctl_pkg::LRST_BIT] & ~lrst_r;

   // Read image of the control register
   // reserved bits zero
   wire [31:0] ctl_image = {8'h00, owner_r, enh_r, 2'b00, power_r, bufwr_r,
                            attach_r, lrst_r, 16'h0000};

   // Next values of the control bits
   always_comb begin
      owner_nxt  = owner_r;
      enh_nxt    = enh_r;
      power_nxt  = power_r;
      bufwr_nxt  = bufwr_r;
      attach_nxt = attach_r;
      if (wr_set) begin
         if (wd[link_ctl_pkg::ENH_BIT] && owner_r && attach_r) begin
            enh_nxt = 1'b1;
         end
         power_nxt  = power_r  | wd[link_ctl_pkg::POWER_BIT];
         bufwr_nxt  = bufwr_r  | wd[link_ctl_pkg::BUFWR_BIT];
         attach_nxt = attach_r | wd[link_ctl_pkg::ATTACH_BIT];
      end else if (wr_clr) begin
         owner_nxt  = owner_r  & ~wd[link_ctl_pkg::OWNER_BIT];
         enh_nxt    = enh_r    & ~wd[link_ctl_pkg::ENH_BIT];
         power_nxt  = power_r  & ~wd[link_ctl_pkg::POWER_BIT];
         bufwr_nxt  = bufwr_r  & ~wd[link_ctl_pkg::BUFWR_BIT];
         attach_nxt = attach_r & ~wd[link_ctl_pkg::ATTACH_BIT];
      end
      if (eeprom_load_valid) begin
         owner_nxt = eeprom_owner_bit;
      end
      if (lrst_go || lrst_r) begin
         enh_nxt    = link_ctl_pkg::CTL_RESET_VAL[link_ctl_pkg::ENH_BIT];
         power_nxt  = link_ctl_pkg::CTL_RESET_VAL[link_ctl_pkg::POWER_BIT];
         bufwr_nxt  = link_ctl_pkg::CTL_RESET_VAL[link_ctl_pkg::BUFWR_BIT];
         attach_nxt = link_ctl_pkg::CTL_RESET_VAL[link_ctl_pkg::ATTACH_BIT];
      end
   end

   // Control bits; owner keeps its EEPROM value through local reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         owner_r  <= link_ctl_pkg::OWNER_RESET;
         enh_r    <= 1'b0;
         power_r  <= 1'b0;
         bufwr_r  <= 1'b0;
         attach_r <= 1'b0;
      end else begin
         owner_r  <= owner_nxt;
         enh_r    <= enh_nxt;
         power_r  <= power_nxt;
         bufwr_r  <= bufwr_nxt;
         attach_r <= attach_nxt;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lrst_r     <= 1'b0;
         lrst_cnt_r <= 8'h00;
      end else if (lrst_go) begin
         lrst_r     <= 1'b1;
         lrst_cnt_r <= 8'h00;
      end else if (lrst_done) begin
         lrst_r     <= 1'b0;
         lrst_cnt_r <= 8'h00;
      end else if (lrst_r) begin
         lrst_cnt_r <= lrst_cnt_r + 8'h01;
      end
   end

   // link clock sampled into the host clock
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sclk_s1_r <= 1'b0;
         sclk_s2_r <= 1'b0;
         sclk_s3_r <= 1'b0;
      end else begin
         sclk_s1_r <= phy_sclk;
         sclk_s2_r <= sclk_s1_r;
         sclk_s3_r <= sclk_s2_r;
      end
   end

   // Link clock watchdog: stopped after IDLE_CYC cycles with no rising edge
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         idle_cnt_r <= 8'h00;
         alive_r    <= 1'b0;
      end else if (sclk_rise) begin
         idle_cnt_r <= 8'h00;
         alive_r    <= 1'b1;
      end else if (idle_cnt_r == IDLE_LAST) begin
         alive_r    <= 1'b0;
      end else begin
         idle_cnt_r <= idle_cnt_r + 8'h01;
      end
   end

   // two stage transfer on link clock edges, flushed by local reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         power_lk1_r  <= 1'b0;
         power_lk2_r  <= 1'b0;
         attach_lk1_r <= 1'b0;
         attach_lk2_r <= 1'b0;
      end else if (lrst_r) begin
         power_lk1_r  <= 1'b0;
         power_lk2_r  <= 1'b0;
         attach_lk1_r <= 1'b0;
         attach_lk2_r <= 1'b0;
      end else if (sclk_rise) begin
         power_lk1_r  <= power_r;
         power_lk2_r  <= power_lk1_r;
         attach_lk1_r <= attach_r;
         attach_lk2_r <= attach_lk1_r;
      end
   end

   // attach status back to the host side
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stat_s1_r <= 1'b0;
         stat_s2_r <= 1'b0;
      end else begin
         stat_s1_r <= attach_lk2_r;
         stat_s2_r <= stat_s1_r;
      end
   end

   // Answer to each request
   always_comb begin
      resp_nxt.abort = 1'b0;
      resp_nxt.rdata = link_ctl_pkg::READ_ZERO;
      if (ctl_hit) begin
         resp_nxt.rdata = ctl_image;
      end else if (stalled) begin
         if (suppress_abort_idle_clock) begin
            resp_nxt.rdata = link_ctl_pkg::ALL_ONES;
         end else begin
            resp_nxt.abort = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         resp_valid_r <= 1'b0;
         resp_r       <= '0;
      end else begin
         resp_valid_r <= req_valid;
         if (req_valid) begin
            resp_r <= resp_nxt;
         end
      end
   end

   // Registered outputs toward the link and the host
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         link_power_on         <= 1'b0;
         phy_enhancements_on   <= 1'b0;
         phy_config_owner_flag <= link_ctl_pkg::OWNER_RESET;
         buffered_write_on     <= 1'b0;
         bus_attach_active     <= 1'b0;
         bus_attach_status     <= 1'b0;
         link_clock_running    <= 1'b0;
         local_reset_active    <= 1'b0;
      end else begin
         link_power_on         <= power_nxt;
         phy_enhancements_on   <= enh_nxt;
         phy_config_owner_flag <= owner_nxt;
         buffered_write_on     <= bufwr_nxt;
         bus_attach_active     <= attach_nxt & attach_lk2_r & power_lk2_r & alive_r;
         bus_attach_status     <= stat_s2_r;
         link_clock_running    <= alive_r;
         local_reset_active    <= lrst_go | (lrst_r & ~lrst_done);
      end
   end

   assign resp_valid = resp_valid_r;
   assign resp       = resp_r;

endmodule
`default_nettype wire

// File: sim/phy_clock_model.sv
// Link clock source standing in for the physical layer
`timescale 1ns/1ns
`default_nettype none
module phy_clock_model (
   input  wire logic power_on,
   output logic      sclk
);
   // Clock runs only while powered, stands low otherwise
   // gated link traffic
   initial begin
      sclk = 1'b0;
      forever begin
         wait (power_on);
         #37 sclk = 1'b1;
         #400 sclk = 1'b0;
         #363;
      end
   end
endmodule
`default_nettype wire

// File: sim/link_host_control_bits_asserts.sv
// Port checks for the link host control bits
`timescale 1ns/1ns
`default_nettype none
module link_host_control_bits_asserts #(
   parameter int RESET_CYC = 8
) (
   input wire logic                        clk_sys,
   input wire logic                        rst_n,
   input wire logic                        req_valid,
   input wire link_ctl_pkg::host_req_type  req,
   input wire logic                        resp_valid,
   input wire link_ctl_pkg::host_resp_type resp,
   input wire logic                        suppress_abort_idle_clock,
   input wire logic                        eeprom_load_valid,
   input wire logic                        eeprom_owner_bit,
   input wire logic                        link_power_on,
   input wire logic                        phy_enhancements_on,
   input wire logic                        phy_config_owner_flag,
   input wire logic                        bus_attach_active,
   input wire logic                        link_clock_running,
   input wire logic                        local_reset_active
);
   int rst_cnt_r;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Request decode
   wire logic set_wr = req_valid && req.write && req.addr == 12'h050;
   wire logic clr_wr = req_valid && req.write && req.addr == 12'h054;
   wire logic win_rd = req_valid && !req.write && ((req.addr >= 12'h0dc && req.addr <= 12'h0f0)
                       || (req.addr >= 12'h100 && req.addr <= 12'h11c));
   wire logic idle_rd = win_rd && !link_clock_running;
   // Cycles spent in local reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) rst_cnt_r <= 0;
      else rst_cnt_r <= local_reset_active ? rst_cnt_r + 1 : 0;
   end
   AST_EEPROM_LOAD:
   assert property (eeprom_load_valid |=> phy_config_owner_flag == $past(eeprom_owner_bit))
      else $error("owner flag not loaded");
   AST_ENH_GATE:
   assert property ($rose(phy_enhancements_on) |-> $past(phy_config_owner_flag))
      else $error("enhancements set without ownership");
   AST_RSVD_ZERO:
   assert property (resp_valid && resp.rdata != 32'hffff_ffff
                    |-> resp.rdata[21:20] == 2'h0 && resp.rdata[15:0] == 16'h0)
      else $error("reserved bits not zero");
   AST_POWER_SET:
   assert property (set_wr && req.wdata[19] && !req.wdata[16] && !local_reset_active
                    |=> link_power_on)
      else $error("power bit not set");
   AST_ABORT:
   assert property (idle_rd && !suppress_abort_idle_clock
                    |=> resp_valid && resp.abort && resp.rdata == 32'h0)
      else $error("missing abort");
   AST_ALL_ONES:
   assert property (idle_rd && suppress_abort_idle_clock
                    |=> resp_valid && !resp.abort && resp.rdata == 32'hffff_ffff)
      else $error("missing all ones answer");
   AST_LRST_ENTRY:
   assert property (set_wr && req.wdata[16] && !local_reset_active
                    |=> (local_reset_active && !link_power_on && !phy_enhancements_on)
                    ##1 !bus_attach_active)
      else $error("local reset did not clear state");
   AST_DETACH:
   assert property (clr_wr && req.wdata[17] |-> ##[1:2] !bus_attach_active)
      else $error("still attached");
   AST_LRST_LEN:
   assert property ($fell(local_reset_active) |-> rst_cnt_r == RESET_CYC)
      else $error("local reset length wrong");
endmodule
bind link_host_control_bits link_host_control_bits_asserts #(.RESET_CYC(RESET_CYC)) i_chk (
   .clk_sys, .rst_n, .req_valid, .req, .resp_valid, .resp, .suppress_abort_idle_clock,
   .eeprom_load_valid, .eeprom_owner_bit, .link_power_on, .phy_enhancements_on,
   .phy_config_owner_flag, .bus_attach_active, .link_clock_running, .local_reset_active);
`default_nettype wire

// File: sim/tb_link_host_control_bits.sv
// Self-checking bench for the link host control bits
`timescale 1ns/1ns
`default_nettype none
module tb_link_host_control_bits;
   logic                        clk_sys = 1'b0;
   logic                        rst_n = 1'b0;
   logic                        req_valid = 1'b0;
   link_ctl_pkg::host_req_type  req = '0;
   logic                        suppress_abort_idle_clock = 1'b0;
   logic                        eeprom_load_valid = 1'b0;
   logic                        eeprom_owner_bit = 1'b0;
   logic                        resp_valid, phy_sclk, link_power_on, phy_enhancements_on;
   logic                        phy_config_owner_flag, buffered_write_on, bus_attach_active;
   logic                        link_clock_running, local_reset_active, bus_attach_status;
   link_ctl_pkg::host_resp_type resp;
   int                          miscompares = 0;
   int                          checked = 0;
   logic [11:0]                 win [5] = '{12'h0dc, 12'h0f0, 12'h100, 12'h11c, 12'h0f4};
   logic [32:0]                 e;

   // 100 ns system clock
   always #50 clk_sys = ~clk_sys;

   link_host_control_bits #(.RESET_CYC(3), .IDLE_CYC(16)) i_dut (
      .clk_sys, .rst_n, .req_valid, .req, .resp_valid, .resp, .suppress_abort_idle_clock,
      .eeprom_load_valid, .eeprom_owner_bit, .phy_sclk, .link_power_on, .phy_enhancements_on,
      .phy_config_owner_flag, .buffered_write_on, .bus_attach_active, .bus_attach_status,
      .link_clock_running, .local_reset_active);
   phy_clock_model i_phy (.power_on(link_power_on), .sclk(phy_sclk));

   // Counts and verdict
   task automatic conclude;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One request, answer checked the cycle after it is taken
   task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] exp);
      @(negedge clk_sys);
      req_valid = 1'b1;
      req = '{write: wr, addr: a, wdata: d};
      @(negedge clk_sys);
      req_valid = 1'b0;
      chk({resp_valid, resp}, {1'b1, exp});
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d);
      acc(1'b0, a, 32'h0, {1'b0, d});
   endtask
   // A write answers with the register image as it stood before the write
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [31:0] img);
      acc(1'b1, a, d, {1'b0, img});
   endtask
   // Bounded wait on the clock alive or attach flag
   task automatic wait_sig(input logic att, input logic want);
      int n;
      for (n = 0; n < 300; n++) begin
         if ((att ? bus_attach_active : link_clock_running) === want) break;
         @(negedge clk_sys);
      end
      if (n == 300) begin
         miscompares++;
         conclude();
      end
   endtask

   // Main sequence
   initial begin
      repeat (8) @(negedge clk_sys);
      rst_n = 1'b1;
      rd(12'h050, 32'h0080_0000);
      rd(12'h054, 32'h0080_0000);
      rd(12'h060, 32'h0);
      for (int s = 0; s < 2; s++) begin
         suppress_abort_idle_clock = s[0];
         for (int i = 0; i < 5; i++) begin
            e = (i == 4) ? 33'h0 : (s == 1) ? {1'b0, 32'hffff_ffff} : {1'b1, 32'h0};
            acc(1'b0, win[i], 32'h0, e);
         end
      end
      suppress_abort_idle_clock = 1'b0;
      wr(12'h050, 32'h000c_0000, 32'h0080_0000);
      rd(12'h050, 32'h008c_0000);
      chk({32'h0, link_power_on, buffered_write_on}, 34'h3);
      wait_sig(1'b0, 1'b1);
      rd(12'h0dc, 32'h0);
      wr(12'h050, 32'h0040_0000, 32'h008c_0000);
      rd(12'h050, 32'h008c_0000);
      wr(12'h050, 32'h0002_0000, 32'h008c_0000);
      wait_sig(1'b1, 1'b1);
      wr(12'h050, 32'h0040_0000, 32'h008e_0000);
      rd(12'h050, 32'h00ce_0000);
      chk({33'h0, phy_enhancements_on}, 34'h1);
      chk({33'h0, bus_attach_status}, 34'h1);
      wr(12'h054, 32'h0002_0000, 32'h00ce_0000);
      rd(12'h050, 32'h00cc_0000);
      chk({33'h0, bus_attach_active}, 34'h0);
      wr(12'h054, 32'h0004_0000, 32'h00cc_0000);
      rd(12'h050, 32'h00c8_0000);
      wr(12'h050, 32'h0001_0000, 32'h00c8_0000);
      rd(12'h050, 32'h0081_0000);
      chk({33'h0, local_reset_active}, 34'h1);
      rd(12'h050, 32'h0080_0000);
      wr(12'h054, 32'h0080_0000, 32'h0080_0000);
      wr(12'h050, 32'h0080_0000, 32'h0000_0000);
      rd(12'h050, 32'h0);
      @(negedge clk_sys);
      eeprom_owner_bit = 1'b1;
      eeprom_load_valid = 1'b1;
      @(negedge clk_sys);
      eeprom_load_valid = 1'b0;
      rd(12'h050, 32'h0080_0000);
      wait_sig(1'b0, 1'b0);
      chk({33'h0, bus_attach_status}, 34'h0);
      acc(1'b0, 12'h100, 32'h0, {1'b1, 32'h0});
      conclude();
   end
endmodule
`default_nettype wire
